// ==== inc/wfd_pkg.sv ====
package wfd_pkg;
    // management register offsets
    localparam logic [15:0] WFD_OFS_BASIC_CTRL  = 16'h0000;
    localparam logic [15:0] WFD_OFS_IRQ_EN      = 16'h0012;
    localparam logic [15:0] WFD_OFS_IRQ_STAT    = 16'h0013;
    localparam logic [15:0] WFD_OFS_WAKE_CTRL   = 16'h4000;
    localparam logic [15:0] WFD_OFS_WAKE_CFG    = 16'h4003;
    localparam logic [15:0] WFD_OFS_STA_0       = 16'h4004;
    localparam logic [15:0] WFD_OFS_STA_1       = 16'h4005;
    localparam logic [15:0] WFD_OFS_STA_2       = 16'h4006;
    // field positions
    localparam int WFD_BIT_SOFT_RST   = 15;
    localparam int WFD_BIT_DETACH     = 10;
    localparam int WFD_BIT_WAKE_IRQ   = 6;
    localparam int WFD_BIT_WAKE_EN    = 2;
    localparam int WFD_BIT_PULSE_MODE = 7;
    localparam int WFD_BIT_WIDTH_LO   = 8;
    // reset values
    localparam logic [15:0] WFD_RST_REG16 = 16'h0000;
    // pattern figures
    localparam logic [7:0] WFD_SYNC_BYTE  = 8'hFF;
    localparam logic [2:0] WFD_SYNC_LEN   = 3'h6;
    localparam logic [2:0] WFD_ADDR_BYTES = 3'h6;
    localparam logic [3:0] WFD_ADDR_REPS  = 4'hF;  // last repetition index
    // wake pulse widths in mclk cycles, selected by the two-bit width field
    localparam logic [7:0] WFD_PULSE_CYC [4] = '{8'h08, 8'h10, 8'h20, 8'h40};

    typedef enum {WFD_HUNT, WFD_MATCH, WFD_FOUND} wfd_state_t;

    // one received byte of a frame
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       last;   // final byte of the frame
        logic       good;   // frame passed length and check-sequence tests, with last
    } wfd_rx_t;

    // one management access
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } wfd_mreq_t;
endpackage

// ==== hdl/wfd_top.sv ====
module wfd_top
    import wfd_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rstn,
    input  wire logic              ce,
    input  wire wfd_pkg::wfd_rx_t  rx_in,
    input  wire wfd_pkg::wfd_mreq_t mreq,
    input  wire logic              wake_irq_strap,
    input  wire logic              led_src,
    input  wire logic              other_irq_n,
    input  wire logic              mac_in_valid,
    output logic [15:0]            reg_rdata_q,
    output logic                   reg_rvalid_q,
    output logic                   shared_irq_n_q,
    output logic                   status_light_a_q,
    output logic                   mac_oe_q,
    output logic                   mac_in_taken_q
);
    import wfd_pkg::*;

    logic [15:0] ctrl_q, irq_en_q, wake_ctrl_q, wake_cfg_q, sta0_q, sta1_q, sta2_q;
    logic        strap_done_q, strap_q;
    logic        wk_stat_q, wk_lvl_q;
    logic [7:0]  pulse_cnt_q;
    wfd_state_t  state_q;
    logic [2:0]  sync_cnt_q, byte_pos_q;
    logic [3:0]  rep_q;
    logic        wake_ev;

    // register decode
    wire        wr_ctrl   = mreq.wr && mreq.addr == WFD_OFS_BASIC_CTRL;
    wire        soft_rst  = wr_ctrl && mreq.wdata[WFD_BIT_SOFT_RST];
    wire        rd_stat   = mreq.rd && mreq.addr == WFD_OFS_IRQ_STAT;
    wire        wake_on   = wake_ctrl_q[WFD_BIT_WAKE_EN];
    wire        pulse_md  = wake_cfg_q[WFD_BIT_PULSE_MODE];
    wire [1:0]  width_sel = wake_cfg_q[WFD_BIT_WIDTH_LO +: 2];
    wire        detach    = ctrl_q[WFD_BIT_DETACH];
    wire [47:0] sta       = {sta0_q, sta1_q, sta2_q};

    // expected byte of the current address copy, top byte first
    wire [7:0]  want_byte = sta[8 * (5 - int'(byte_pos_q)) +: 8];
    wire        rxv       = rx_in.valid;
    wire        is_sync   = rx_in.data == WFD_SYNC_BYTE;
    wire        addr_hit  = rx_in.data == want_byte;
    wire        sync_full = sync_cnt_q == WFD_SYNC_LEN;
    wire        last_pos  = byte_pos_q == WFD_ADDR_BYTES - 3'h1;
    wire        last_rep  = rep_q == WFD_ADDR_REPS;
    wire        match_end = last_pos && last_rep && addr_hit;

    // frame outcome: found pattern plus a good frame end makes a wake
    wire        found_now = state_q == WFD_FOUND || (state_q == WFD_MATCH && match_end);
    assign wake_ev = ce && wake_on && rxv && rx_in.last && rx_in.good && found_now;

    // read data mux
    logic [15:0] rd_mux;
    always_comb
    begin
        rd_mux = 16'h0000;
        case (mreq.addr)
            WFD_OFS_BASIC_CTRL: rd_mux = ctrl_q;
            WFD_OFS_IRQ_EN:     rd_mux = irq_en_q;
            WFD_OFS_IRQ_STAT:   rd_mux = 16'(wk_stat_q) << WFD_BIT_WAKE_IRQ;
            WFD_OFS_WAKE_CTRL:  rd_mux = wake_ctrl_q;
            WFD_OFS_WAKE_CFG:   rd_mux = wake_cfg_q;
            WFD_OFS_STA_0:      rd_mux = sta0_q;
            WFD_OFS_STA_1:      rd_mux = sta1_q;
            WFD_OFS_STA_2:      rd_mux = sta2_q;
            default:            rd_mux = 16'h0000;
        endcase
    end

    // writable registers; soft reset clears them but not the strap
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_q      <= WFD_RST_REG16;
            irq_en_q    <= WFD_RST_REG16;
            wake_ctrl_q <= WFD_RST_REG16;
            wake_cfg_q  <= WFD_RST_REG16;
            sta0_q      <= WFD_RST_REG16;
            sta1_q      <= WFD_RST_REG16;
            sta2_q      <= WFD_RST_REG16;
        end
        else if (ce && soft_rst)
        begin
            ctrl_q      <= WFD_RST_REG16;
            irq_en_q    <= WFD_RST_REG16;
            wake_ctrl_q <= WFD_RST_REG16;
            wake_cfg_q  <= WFD_RST_REG16;
            sta0_q      <= WFD_RST_REG16;
            sta1_q      <= WFD_RST_REG16;
            sta2_q      <= WFD_RST_REG16;
        end
        else if (ce && mreq.wr)
        begin
            if (wr_ctrl) ctrl_q <= mreq.wdata;
            if (mreq.addr == WFD_OFS_IRQ_EN) irq_en_q <= mreq.wdata;
            if (mreq.addr == WFD_OFS_WAKE_CTRL) wake_ctrl_q <= mreq.wdata;
            if (mreq.addr == WFD_OFS_WAKE_CFG) wake_cfg_q <= mreq.wdata;
            if (mreq.addr == WFD_OFS_STA_0) sta0_q <= mreq.wdata;
            if (mreq.addr == WFD_OFS_STA_1) sta1_q <= mreq.wdata;
            if (mreq.addr == WFD_OFS_STA_2) sta2_q <= mreq.wdata;
        end
    end

    // read answer one cycle after the strobe
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_rdata_q  <= 16'h0000;
            reg_rvalid_q <= 1'b0;
        end
        else if (ce)
        begin
            reg_rdata_q  <= mreq.rd ? rd_mux : 16'h0000;
            reg_rvalid_q <= mreq.rd;
        end
    end

    // strap caught once, at the first enabled edge after hardware reset release
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            strap_done_q <= 1'b0;
            strap_q      <= 1'b0;
        end
        else if (ce && !strap_done_q)
        begin
            strap_done_q <= 1'b1;
            strap_q      <= wake_irq_strap;
        end
    end

    // pattern matcher: counts sync bytes, then walks 16 copies of 6 address bytes
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q    <= WFD_HUNT;
            sync_cnt_q <= 3'h0;
            byte_pos_q <= 3'h0;
            rep_q      <= 4'h0;
        end
        else if (ce && rxv && (rx_in.last || !wake_on))
        begin
            state_q    <= WFD_HUNT;  // each frame scanned from scratch
            sync_cnt_q <= 3'h0;
            byte_pos_q <= 3'h0;
            rep_q      <= 4'h0;
        end
        else if (ce && rxv)
        begin
            case (state_q)
                WFD_HUNT:
                begin
                    // any byte position, no destination filter
                    if (sync_full && addr_hit && !is_sync)
                    begin
                        state_q    <= WFD_MATCH;
                        byte_pos_q <= 3'h1;
                        rep_q      <= 4'h0;
                    end
                    else if (is_sync)
                        sync_cnt_q <= sync_full ? sync_cnt_q : sync_cnt_q + 3'h1;
                    else
                        sync_cnt_q <= 3'h0;
                end
                WFD_MATCH:
                begin
                    if (!addr_hit)
                    begin
                        state_q    <= WFD_HUNT;
                        sync_cnt_q <= is_sync ? 3'h1 : 3'h0;
                        byte_pos_q <= 3'h0;
                    end
                    else if (match_end)
                        state_q <= WFD_FOUND;
                    else if (last_pos)
                    begin
                        byte_pos_q <= 3'h0;
                        rep_q      <= rep_q + 4'h1;
                    end
                    else
                        byte_pos_q <= byte_pos_q + 3'h1;
                end
                WFD_FOUND:
                    state_q <= WFD_FOUND;
                default:
                    state_q <= WFD_HUNT;
            endcase
        end
    end

    // wake status: event wins over the clearing read; level follows until disabled
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            wk_stat_q   <= 1'b0;
            wk_lvl_q    <= 1'b0;
            pulse_cnt_q <= 8'h00;
        end
        else if (ce)
        begin
            wk_stat_q <= wake_ev || (wk_stat_q && !rd_stat && !soft_rst);
            wk_lvl_q  <= wake_ev || (wk_lvl_q && wake_on && !soft_rst);
            if (wake_ev && pulse_md)
                pulse_cnt_q <= WFD_PULSE_CYC[width_sel];
            else if (pulse_cnt_q != 8'h00)
                pulse_cnt_q <= pulse_cnt_q - 8'h01;
        end
    end

    // dedicated wake line: level in level mode, counted pulse in pulse mode
    wire wake_line  = pulse_md ? (pulse_cnt_q != 8'h00) : wk_lvl_q;
    // level mode keeps the shared line low past the status read, by design
    wire shared_wk  = irq_en_q[WFD_BIT_WAKE_IRQ] && (wk_stat_q || (!pulse_md && wk_lvl_q));

    // pin drivers
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            shared_irq_n_q   <= 1'b1;
            status_light_a_q <= 1'b0;
            mac_oe_q         <= 1'b0;
            mac_in_taken_q   <= 1'b0;
        end
        else if (ce)
        begin
            shared_irq_n_q   <= other_irq_n && !shared_wk;
            status_light_a_q <= strap_q ? !wake_line : led_src;
            mac_oe_q         <= !detach;
            mac_in_taken_q   <= mac_in_valid && !detach;
        end
    end

    // checks
    sequence sync_seen_s;
        sync_full && rxv && !rx_in.last;
    endsequence

    property sixteen_copies_p;
        @(posedge mclk) disable iff (!rstn)
        (ce && wake_on && state_q == WFD_MATCH && rxv && match_end && !rx_in.last)
        |=> state_q == WFD_FOUND;
    endproperty

    copy_found_a: assert property (sixteen_copies_p)
        else $error("last address byte did not finish the match");

    start_after_sync_a: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && state_q == WFD_HUNT && $past(state_q) == WFD_HUNT) ##1 state_q == WFD_MATCH
        |-> $past(sync_full))
        else $error("match began without a full sync run");

    sync_then_match_a: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && wake_on && state_q == WFD_HUNT) ##0 sync_seen_s ##0 (addr_hit && !is_sync)
        |=> state_q == WFD_MATCH && byte_pos_q == 3'h1)
        else $error("sync plus first address byte not accepted");

    miss_restart_a: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && rxv && !rx_in.last && wake_on && state_q == WFD_MATCH && !addr_hit)
        |=> state_q == WFD_HUNT && byte_pos_q == 3'h0)
        else $error("mismatch did not abandon the attempt");

    bad_frame_a: assert property (@(posedge mclk) disable iff (!rstn)
        (rxv && rx_in.last && !rx_in.good && !wk_stat_q) |=> !wk_stat_q || $past(rd_stat))
        else $error("bad frame raised wake status");

    disabled_quiet_a: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && rxv && !wake_on) |=> state_q == WFD_HUNT && sync_cnt_q == 3'h0)
        else $error("matcher not idle while detection disabled");

    pulse_width_a: assert property (@(posedge mclk) disable iff (!rstn)
        (wake_ev && pulse_md && width_sel == 2'h0 && !soft_rst ##1 ce [*8])
        |=> pulse_cnt_q == 8'h00)
        else $error("wake pulse width wrong");

    stat_read_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && rd_stat && !wake_ev) |=> !wk_stat_q)
        else $error("status read did not clear wake status");

    set_wins_a: assert property (@(posedge mclk) disable iff (!rstn)
        wake_ev |=> wk_stat_q)
        else $error("wake event lost");

    shared_low_a: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && wake_ev && irq_en_q[WFD_BIT_WAKE_IRQ] && !soft_rst) ##1 ce |=> !shared_irq_n_q)
        else $error("shared interrupt not asserted on wake");

    detach_pins_a: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && detach) |=> !mac_oe_q && !mac_in_taken_q)
        else $error("MAC pins active while detached");

    strap_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        strap_done_q |=> $stable(strap_q))
        else $error("strap resampled after release");
endmodule

// ==== testbench/wfd_mac_model.sv ====
// far side: the MAC and its management software
module wfd_mac_model
    import wfd_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic [15:0] reg_rdata_q,
    input  wire logic        reg_rvalid_q,
    output wfd_pkg::wfd_rx_t   rx_in,
    output wfd_pkg::wfd_mreq_t mreq
);
    timeunit 1ns;
    timeprecision 1ps;

    // no power-down request exists here, so the receive path stays live
    initial
    begin
        rx_in = '0;
        mreq  = '0;
    end

    // one byte per cycle; released data shows the inverse of its last value
    task automatic send_frame(input logic [7:0] q[$], input logic good);
        foreach (q[i])
        begin
            @(posedge mclk);
            #2;
            rx_in = '{1'b1, q[i], i == q.size() - 1, good && (i == q.size() - 1)};
        end
        @(posedge mclk);
        #2;
        rx_in = '{1'b0, ~rx_in.data, 1'b0, 1'b0};
    endtask

    // write strobe held for exactly one taken edge
    task automatic reg_wr(input logic [15:0] addr, input logic [15:0] data);
        @(posedge mclk);
        #2;
        mreq = '{1'b0, 1'b1, addr, data};
        @(posedge mclk);
        #2;
        mreq = '{1'b0, 1'b0, ~addr, ~data};
    endtask

    // answer is registered on the taking edge, so it is read just after it
    task automatic reg_rd(input logic [15:0] addr, output logic [15:0] data, output logic rv);
        @(posedge mclk);
        #2;
        mreq = '{1'b1, 1'b0, addr, mreq.wdata};
        @(posedge mclk);
        #2;
        data = reg_rdata_q;
        rv   = reg_rvalid_q;
        mreq = '{1'b0, 1'b0, ~addr, mreq.wdata};
    endtask
endmodule

// ==== testbench/tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import wfd_pkg::*;

    localparam logic [47:0] STA = 48'h0123_456789AB;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic        ce = 1'b1;
    logic        strap = 1'b1;
    logic        led_src = 1'b0;
    logic        other_n = 1'b1;
    logic        mac_in_valid = 1'b0;
    wfd_rx_t     rx_in;
    wfd_mreq_t   mreq;
    logic [15:0] rdata;
    logic        rvalid;
    logic        shared_n;
    logic        light;
    logic        mac_oe;
    logic        taken;
    logic [15:0] rd_v;
    logic        rd_ok;
    logic [7:0]  frm[$];
    int          n_errors = 0;
    int          tests_run = 0;

    always #12.5 mclk = ~mclk;

    wfd_top dut (.mclk(mclk), .rstn(rstn), .ce(ce), .rx_in(rx_in), .mreq(mreq),
        .wake_irq_strap(strap), .led_src(led_src), .other_irq_n(other_n),
        .mac_in_valid(mac_in_valid), .reg_rdata_q(rdata), .reg_rvalid_q(rvalid),
        .shared_irq_n_q(shared_n), .status_light_a_q(light), .mac_oe_q(mac_oe),
        .mac_in_taken_q(taken));
    wfd_mac_model mac (.mclk(mclk), .reg_rdata_q(rdata), .reg_rvalid_q(rvalid),
        .rx_in(rx_in), .mreq(mreq));

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask

    task automatic rd_chk(input string what, input logic [15:0] a, input logic [15:0] exp);
        mac.reg_rd(a, rd_v, rd_ok);
        chk({what, " rvalid"}, 16'(rd_ok), 16'h0001);
        chk(what, rd_v, exp);
    endtask

    task automatic set_sta;
        mac.reg_wr(WFD_OFS_STA_0, STA[47:32]);
        mac.reg_wr(WFD_OFS_STA_1, STA[31:16]);
        mac.reg_wr(WFD_OFS_STA_2, STA[15:0]);
    endtask

    // frame head: foreign destination, source and a few filler bytes
    task automatic hdr;
        frm.delete();
        for (int i = 0; i < 15; i++)
            frm.push_back(8'(i + 16));
    endtask

    task automatic pat(input int nff, input int nrep, input int bad_at, input bit swap);
        repeat (nff) frm.push_back(8'hFF);
        for (int i = 0; i < nrep * 6; i++)
            frm.push_back(i == bad_at ? 8'h55 :
                swap ? STA[8*(i%6) +: 8] : STA[47-8*(i%6) -: 8]);
    endtask

    task automatic t_case(input string nm, input logic good, input logic [15:0] exp);
        repeat (4) frm.push_back(8'hC3);
        mac.send_frame(frm, good);
        cycles(3);
        mac.reg_rd(WFD_OFS_IRQ_STAT, rd_v, rd_ok);
        chk(nm, rd_v & 16'h0040, exp);
    endtask

    task automatic t_regs;
        logic [15:0] ofs [8] = '{WFD_OFS_BASIC_CTRL, WFD_OFS_IRQ_EN, WFD_OFS_IRQ_STAT,
            WFD_OFS_WAKE_CTRL, WFD_OFS_WAKE_CFG, WFD_OFS_STA_0, WFD_OFS_STA_1, WFD_OFS_STA_2};
        foreach (ofs[i])
            rd_chk("reset value", ofs[i], WFD_RST_REG16);
        set_sta();
        rd_chk("address hi", WFD_OFS_STA_0, STA[47:32]);
        rd_chk("address lo", WFD_OFS_STA_2, STA[15:0]);
        mac.reg_wr(16'h0055, 16'hBEEF);
        rd_chk("unmapped", 16'h0055, 16'h0000);
        $display("test regs done");
    endtask

    task automatic t_level;
        mac.reg_wr(WFD_OFS_IRQ_EN, 16'h0040);
        mac.reg_wr(WFD_OFS_WAKE_CFG, 16'h0000);
        mac.reg_wr(WFD_OFS_WAKE_CTRL, 16'h0004);
        rd_chk("wake ctrl", WFD_OFS_WAKE_CTRL, 16'h0004);
        hdr();
        pat(8, 16, -1, 0);
        repeat (4) frm.push_back(8'hC3);
        mac.send_frame(frm, 1'b1);
        // the pin register lags the wake flag by one edge, so the light is still idle here
        chk("light early", 16'(light), 16'h0001);
        cycles(1);
        chk("wake light", 16'(light), 16'h0000);
        chk("shared wake", 16'(shared_n), 16'h0000);
        cycles(30);
        chk("level held", 16'(light), 16'h0000);
        rd_chk("status set", WFD_OFS_IRQ_STAT, 16'h0040);
        rd_chk("status clr", WFD_OFS_IRQ_STAT, 16'h0000);
        chk("level shared", 16'(shared_n), 16'h0000);
        mac.reg_wr(WFD_OFS_WAKE_CTRL, 16'h0000);
        cycles(2);
        chk("level off", 16'(light), 16'h0001);
        $display("test level done");
    endtask

    task automatic t_soft;
        strap = 1'b0;
        mac.reg_wr(WFD_OFS_BASIC_CTRL, 16'h8000);
        cycles(2);
        chk("strap kept", 16'(light), 16'h0001);
        rd_chk("soft cleared", WFD_OFS_STA_0, 16'h0000);
        chk("shared idle", 16'(shared_n), 16'h0001);
        $display("test soft reset done");
    endtask

    task automatic t_pulse;
        int n;
        set_sta();
        mac.reg_wr(WFD_OFS_IRQ_EN, 16'h0040);
        mac.reg_wr(WFD_OFS_WAKE_CTRL, 16'h0004);
        for (int sel = 0; sel < 4; sel++)
        begin
            mac.reg_wr(WFD_OFS_WAKE_CFG, 16'h0080 | 16'(sel << 8));
            hdr();
            pat(6, 16, -1, 0);
            repeat (4) frm.push_back(8'hC3);
            mac.send_frame(frm, 1'b1);
            n = 0;
            repeat (100)
            begin
                @(posedge mclk);
                #2;
                if (light === 1'b0)
                    n++;
            end
            chk("pulse width", 16'(n), 16'(8 << sel));
            chk("shared held", 16'(shared_n), 16'h0000);
            rd_chk("pulse status", WFD_OFS_IRQ_STAT, 16'h0040);
            cycles(2);
            chk("shared freed", 16'(shared_n), 16'h0001);
        end
        other_n = 1'b0;
        cycles(2);
        chk("wired and", 16'(shared_n), 16'h0000);
        other_n = 1'b1;
        $display("test pulse done");
    endtask

    task automatic t_reject;
        hdr();
        pat(6, 16, -1, 0);
        t_case("bad fcs", 1'b0, 16'h0000);
        hdr();
        pat(6, 15, -1, 0);
        t_case("short body", 1'b1, 16'h0000);
        hdr();
        pat(5, 16, -1, 0);
        t_case("short sync", 1'b1, 16'h0000);
        hdr();
        pat(6, 16, -1, 1);
        t_case("byte order", 1'b1, 16'h0000);
        hdr();
        pat(6, 16, 40, 0);
        pat(6, 16, -1, 0);
        t_case("restart", 1'b1, 16'h0040);
        mac.reg_wr(WFD_OFS_WAKE_CTRL, 16'h0000);
        hdr();
        pat(6, 16, -1, 0);
        t_case("disabled", 1'b1, 16'h0000);
        $display("test reject done");
    endtask

    task automatic t_detach;
        mac.reg_wr(WFD_OFS_BASIC_CTRL, 16'h0400);
        cycles(1);
        chk("pins float", 16'(mac_oe), 16'h0000);
        mac_in_valid = 1'b1;
        cycles(1);
        mac_in_valid = 1'b0;
        chk("input ignored", 16'(taken), 16'h0000);
        mac.reg_wr(WFD_OFS_BASIC_CTRL, 16'h0000);
        cycles(1);
        chk("pins drive", 16'(mac_oe), 16'h0001);
        mac_in_valid = 1'b1;
        cycles(1);
        mac_in_valid = 1'b0;
        chk("input taken", 16'(taken), 16'h0001);
        // with the clock enable low a detach write must not land
        ce = 1'b0;
        mac.reg_wr(WFD_OFS_BASIC_CTRL, 16'h0400);
        ce = 1'b1;
        cycles(1);
        chk("frozen write", 16'(mac_oe), 16'h0001);
        $display("test detach done");
    endtask

    // hardware reset resamples the strap, now low: light follows its source
    task automatic t_hw;
        rstn = 1'b0;
        cycles(3);
        rstn = 1'b1;
        led_src = 1'b1;
        cycles(2);
        chk("led on", 16'(light), 16'h0001);
        led_src = 1'b0;
        cycles(2);
        chk("led off", 16'(light), 16'h0000);
        $display("test strap done");
    endtask

    // main sequence
    initial
    begin
        cycles(3);
        rstn = 1'b1;
        cycles(1);
        t_regs();
        t_level();
        t_soft();
        t_pulse();
        t_reject();
        t_detach();
        t_hw();
        complete_run();
    end

    // hang guard
    initial
    begin
        repeat (90000) @(posedge mclk);
        n_errors++;
        complete_run();
    end
endmodule
